// *** logic/tio_chan_matrix.sv ***
/*
 * Wired channel matrix: for a channel number gives its interrupt response
 * address, device code, direction and speed code.
 * Assumes the channel number is below the channel count.
 */
`timescale 1ns/10ps
module tio_chan_matrix (
   input wire logic [tio_pkg::CH_W-1:0] chan,
   output logic [tio_pkg::ADDR_W-1:0] resp_addr,
   output logic [tio_pkg::DEV_W-1:0] dev_code,
   output logic dir_out,
   output logic [tio_pkg::SPD_W-1:0] channel_speed_code
);
   logic [tio_pkg::ADDR_W-1:0] addr_tab [tio_pkg::NUM_CH];
   logic [tio_pkg::SPD_W-1:0] spd_tab [tio_pkg::NUM_CH];

   // fixed per-channel wiring, no software can alter it
   genvar gi;
   generate
      for (gi = 0; gi < tio_pkg::NUM_CH; gi++) begin : g_row
         assign addr_tab[gi] = tio_pkg::RESP_BASE
            + tio_pkg::ADDR_W'(gi);
         assign spd_tab[gi] = tio_pkg::FAST_MASK[gi] ? tio_pkg::SPD_HI_A
            : tio_pkg::SPD_LO_A;
      end
   endgenerate

   always_comb begin
      resp_addr = addr_tab[chan];
      dev_code = chan;
      dir_out = tio_pkg::DIR_OUT_MASK[chan];
      channel_speed_code = spd_tab[chan];
   end
endmodule : tio_chan_matrix

// *** logic/tio_pack_unit.sv ***
/*
 * Character packer: rotates the buffer word by the packing mode, clears it
 * before the first input character and merges or extracts one character.
 * Assumes the caller supplies the packing mode of the current control word.
 */
`timescale 1ns/10ps
module tio_pack_unit (
   input wire logic [tio_pkg::WORD_W-1:0] word_in,
   input wire logic [1:0] pmode,
   input wire logic first_char,
   input wire logic dir_out,
   input wire logic [tio_pkg::WORD_W-1:0] dev_char,
   output logic [tio_pkg::WORD_W-1:0] word_out,
   output logic [tio_pkg::WORD_W-1:0] char_out
);
   logic [tio_pkg::WORD_W-1:0] src;
   logic [tio_pkg::WORD_W-1:0] rot;
   logic [tio_pkg::WORD_W-1:0] mask;

   always_comb begin
      src = (first_char && !dir_out) ? '0 : word_in;
      case (pmode)
         tio_pkg::PMODE_FOUR: begin
            rot = {src[17:0], src[23:18]};
            mask = tio_pkg::MASK_FOUR;
         end
         tio_pkg::PMODE_THREE: begin
            rot = {src[15:0], src[23:16]};
            mask = tio_pkg::MASK_THREE;
         end
         tio_pkg::PMODE_TWO: begin
            rot = {src[11:0], src[23:12]};
            mask = tio_pkg::MASK_TWO;
         end
         default: begin
            rot = src;
            mask = '1;
         end
      endcase
      word_out = dir_out ? rot : (rot | (dev_char & mask));
      char_out = rot & mask;
   end
endmodule : tio_pack_unit

// *** logic/tio_sequencer.sv ***
/*
 * Table transfer sequencer: services peripheral channel interrupts by a
 * fixed hardware sequence that fetches and updates the channel control
 * word and moves one character between the device and core memory.
 * Assumes a memory port with one-cycle read latency and no wait states,
 * a device port on this clock, and interrupt lines from outside the clock.
 */
`timescale 1ns/10ps
module tio_sequencer #(
   parameter int SLOW_CYCLES = tio_pkg::SLOW_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [tio_pkg::NUM_CH-1:0] chan_irq,
   output logic mem_rd,
   output logic mem_wr,
   output logic [tio_pkg::ADDR_W-1:0] mem_addr,
   output logic [tio_pkg::WORD_W-1:0] mem_wdata,
   input wire logic [tio_pkg::WORD_W-1:0] mem_rdata,
   output logic [tio_pkg::DEV_W-1:0] dev_code,
   output logic dev_in_ack,
   output logic dev_out_strobe,
   output logic [tio_pkg::WORD_W-1:0] dev_out_data,
   input wire logic [tio_pkg::WORD_W-1:0] dev_in_data,
   output logic cpu_hold,
   output logic table_done,
   output logic [tio_pkg::CH_W-1:0] table_done_chan,
   input wire logic [tio_pkg::RADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq
);
   localparam int FAST_CYCLES = tio_pkg::FAST_CYC;

   tio_pkg::tio_state_type state_ff, nxt_state;
   logic [tio_pkg::NUM_CH-1:0] sync1_ff, sync2_ff, sync3_ff, level_ff;
   logic [tio_pkg::NUM_CH-1:0] rise, pend_ff;
   logic [tio_pkg::CH_W-1:0] chan_ff, pick;
   logic pick_ok;
   logic [tio_pkg::ADDR_W-1:0] m_resp;
   logic [tio_pkg::DEV_W-1:0] m_dev;
   logic m_dir;
   logic [tio_pkg::SPD_W-1:0] m_spd;
   logic dir_ff, fast_ff, first_ff;
   logic [tio_pkg::ADDR_W-1:0] resp_ff;
   logic [tio_pkg::WORD_W-1:0] cw_ff;
   logic [tio_pkg::TMR_W-1:0] tmr_ff;
   logic pad_done;
   logic [tio_pkg::ADDR_W-1:0] cw_y, new_y;
   logic [1:0] cw_c, cw_p, new_c;
   logic [2:0] c_sum;
   logic [tio_pkg::N_W-1:0] cw_n, new_n;
   logic [tio_pkg::WORD_W-1:0] new_cw;
   logic done_now;
   logic [tio_pkg::WORD_W-1:0] pk_word, pk_char;
   logic en_ff;
   logic [tio_pkg::IRQ_W-1:0] istat_ff, imask_ff, ev;
   logic done_ev_ff, xfer_ev_ff;

   // three-stage capture of asynchronous channel lines
   genvar gi;
   generate
      for (gi = 0; gi < tio_pkg::NUM_CH; gi++) begin : g_sync
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
               sync3_ff[gi] <= 1'b0;
               level_ff[gi] <= 1'b0;
            end else begin
               sync1_ff[gi] <= chan_irq[gi];
               sync2_ff[gi] <= sync1_ff[gi];
               sync3_ff[gi] <= sync2_ff[gi];
               if (sync2_ff[gi] == sync3_ff[gi]) begin
                  level_ff[gi] <= sync3_ff[gi];
               end
            end
         end
         assign rise[gi] = (sync2_ff[gi] == sync3_ff[gi]) && sync3_ff[gi]
            && !level_ff[gi];
      end
   endgenerate

   // lowest channel wins; one pending bit per channel
   always_comb begin
      pick = '0;
      pick_ok = 1'b0;
      for (int i = tio_pkg::NUM_CH - 1; i >= 0; i--) begin
         if (pend_ff[i]) begin
            pick = tio_pkg::CH_W'(i);
            pick_ok = 1'b1;
         end
      end
   end

   // a new edge in the clearing cycle keeps the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_ff <= '0;
      end else begin
         for (int i = 0; i < tio_pkg::NUM_CH; i++) begin
            if (rise[i]) begin
               pend_ff[i] <= 1'b1;
            end else if (state_ff == tio_pkg::S_IDLE && en_ff && pick_ok
               && pick == tio_pkg::CH_W'(i)) begin
               pend_ff[i] <= 1'b0;
            end
         end
      end
   end

   tio_chan_matrix u_matrix (
      .chan(pick),
      .resp_addr(m_resp),
      .dev_code(m_dev),
      .dir_out(m_dir),
      .channel_speed_code(m_spd)
   );

   // control word update
   always_comb begin
      cw_y = mem_rdata[tio_pkg::Y_LSB +: tio_pkg::ADDR_W];
      cw_p = mem_rdata[tio_pkg::P_LSB +: 2];
      cw_c = mem_rdata[tio_pkg::C_LSB +: 2];
      cw_n = mem_rdata[tio_pkg::N_LSB +: tio_pkg::N_W];
      new_y = cw_y + tio_pkg::ADDR_W'(cw_c == cw_p);
      c_sum = {1'b0, cw_c} + 3'h1;
      new_n = cw_n + tio_pkg::N_W'(c_sum[2]);
      new_c = (c_sum[1:0] == tio_pkg::C_ZERO) ? cw_p : c_sum[1:0];
      done_now = c_sum[2] && (new_n == tio_pkg::N_DONE);
      new_cw = mem_rdata;
      new_cw[tio_pkg::Y_LSB +: tio_pkg::ADDR_W] = new_y;
      new_cw[tio_pkg::C_LSB +: 2] = new_c;
      new_cw[tio_pkg::N_LSB +: tio_pkg::N_W] = new_n;
   end

   tio_pack_unit u_pack (
      .word_in(mem_rdata),
      .pmode(cw_ff[tio_pkg::P_LSB +: 2]),
      .first_char(first_ff),
      .dir_out(dir_ff),
      .dev_char(dev_in_data),
      .word_out(pk_word),
      .char_out(pk_char)
   );

   assign pad_done = fast_ff ? (tmr_ff >= tio_pkg::TMR_W'(FAST_CYCLES - 1))
      : (tmr_ff >= tio_pkg::TMR_W'(SLOW_CYCLES - 1));

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         tio_pkg::S_IDLE: begin
            if (en_ff && pick_ok) begin
               nxt_state = tio_pkg::S_CW_RD;
            end
         end
         tio_pkg::S_CW_RD: nxt_state = tio_pkg::S_CW_UPD;
         tio_pkg::S_CW_UPD: nxt_state = tio_pkg::S_CW_WR;
         tio_pkg::S_CW_WR: nxt_state = tio_pkg::S_DAT_RD;
         tio_pkg::S_DAT_RD: nxt_state = tio_pkg::S_DAT_XF;
         tio_pkg::S_DAT_XF: nxt_state = tio_pkg::S_DAT_WR;
         tio_pkg::S_DAT_WR: nxt_state = tio_pkg::S_PAD;
         tio_pkg::S_PAD: begin
            if (pad_done) begin
               nxt_state = tio_pkg::S_IDLE;
            end
         end
         default: nxt_state = tio_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= tio_pkg::S_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // channel context latched at service start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chan_ff <= '0;
         resp_ff <= '0;
         dir_ff <= 1'b0;
         fast_ff <= 1'b0;
         dev_code <= '0;
      end else if (state_ff == tio_pkg::S_IDLE && en_ff && pick_ok) begin
         chan_ff <= pick;
         resp_ff <= m_resp;
         dir_ff <= m_dir;
         fast_ff <= (m_spd == tio_pkg::SPD_HI_A)
            || (m_spd == tio_pkg::SPD_HI_B);
         dev_code <= m_dev;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cw_ff <= '0;
         first_ff <= 1'b0;
         done_ev_ff <= 1'b0;
      end else if (state_ff == tio_pkg::S_CW_UPD) begin
         cw_ff <= new_cw;
         first_ff <= (cw_c == cw_p);
         done_ev_ff <= done_now;
      end else if (state_ff == tio_pkg::S_IDLE) begin
         done_ev_ff <= 1'b0;
      end
   end

   // cycle timer pads every service to its fixed length
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tmr_ff <= '0;
      end else if (state_ff == tio_pkg::S_IDLE) begin
         tmr_ff <= '0;
      end else if (!pad_done) begin
         tmr_ff <= tmr_ff + tio_pkg::TMR_W'(1);
      end
   end

   // memory port; only control words and table words are touched
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_addr <= '0;
         mem_wdata <= '0;
      end else begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         case (nxt_state)
            tio_pkg::S_CW_RD: begin
               mem_rd <= 1'b1;
               mem_addr <= m_resp;
            end
            tio_pkg::S_CW_WR: begin
               mem_wr <= 1'b1;
               mem_addr <= resp_ff;
               mem_wdata <= new_cw;
            end
            tio_pkg::S_DAT_RD: begin
               mem_rd <= 1'b1;
               mem_addr <= cw_ff[tio_pkg::Y_LSB +: tio_pkg::ADDR_W];
            end
            tio_pkg::S_DAT_WR: begin
               mem_wr <= 1'b1;
               mem_wdata <= pk_word;
            end
            default: begin
            end
         endcase
      end
   end

   // exactly one character per service
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dev_in_ack <= 1'b0;
         dev_out_strobe <= 1'b0;
         dev_out_data <= '0;
      end else begin
         dev_in_ack <= 1'b0;
         dev_out_strobe <= 1'b0;
         if (state_ff == tio_pkg::S_DAT_XF) begin
            if (dir_ff) begin
               dev_out_strobe <= 1'b1;
               dev_out_data <= pk_char;
            end else begin
               dev_in_ack <= 1'b1;
            end
         end
      end
   end

   // program is frozen, never altered, while the sequence owns memory
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cpu_hold <= 1'b0;
      end else begin
         cpu_hold <= (nxt_state != tio_pkg::S_IDLE);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         table_done <= 1'b0;
         table_done_chan <= '0;
         xfer_ev_ff <= 1'b0;
      end else begin
         xfer_ev_ff <= (state_ff == tio_pkg::S_PAD) && pad_done;
         table_done <= (state_ff == tio_pkg::S_PAD) && pad_done
            && done_ev_ff;
         if ((state_ff == tio_pkg::S_PAD) && pad_done && done_ev_ff) begin
            table_done_chan <= chan_ff;
         end
      end
   end

   // register file
   assign ev[tio_pkg::IRQ_DONE_BIT] = table_done;
   assign ev[tio_pkg::IRQ_XFER_BIT] = xfer_ev_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_ff <= tio_pkg::CTRL_RST;
         imask_ff <= tio_pkg::MASK_RST;
      end else if (reg_wr) begin
         if (reg_addr == tio_pkg::REG_CTRL) begin
            en_ff <= reg_wdata[0];
         end
         if (reg_addr == tio_pkg::REG_IRQ_MASK) begin
            imask_ff <= reg_wdata[tio_pkg::IRQ_W-1:0];
         end
      end
   end

   // set beats write-one-to-clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         istat_ff <= '0;
      end else begin
         for (int i = 0; i < tio_pkg::IRQ_W; i++) begin
            if (ev[i]) begin
               istat_ff[i] <= 1'b1;
            end else if (reg_wr && reg_addr == tio_pkg::REG_IRQ_STAT
               && reg_wdata[i]) begin
               istat_ff[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_ff & imask_ff);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               tio_pkg::REG_CTRL: reg_rdata <= {31'h00000000, en_ff};
               tio_pkg::REG_STAT: reg_rdata <= {17'h00000, chan_ff,
                  table_done_chan, 2'h0, (state_ff != tio_pkg::S_IDLE)};
               tio_pkg::REG_IRQ_STAT: reg_rdata <= {30'h00000000, istat_ff};
               tio_pkg::REG_IRQ_MASK: reg_rdata <= {30'h00000000, imask_ff};
               tio_pkg::REG_LAST_CW: reg_rdata <= {8'h00, cw_ff};
               default: reg_rdata <= '0;
            endcase
         end
      end
   end
endmodule : tio_sequencer

// *** pkg/tio_pkg.sv ***
/*
 * Shared constants for the table transfer sequencer: control word fields,
 * register offsets, reset values, channel matrix contents, sequence timing
 * and the sequencer state type.
 * Assumes a 200 MHz clock and a 24-bit core memory of 16K words.
 */
package tio_pkg;
   localparam int NUM_CH = 48;
   localparam int CH_W = 6;
   localparam int WORD_W = 24;
   localparam int ADDR_W = 14;
   localparam int DEV_W = 6;
   localparam int SPD_W = 3;
   localparam int RADDR_W = 8;

   // control word fields
   localparam int Y_LSB = 0;
   localparam int P_LSB = 14;
   localparam int C_LSB = 16;
   localparam int N_LSB = 18;
   localparam int N_W = 6;
   localparam logic [N_W-1:0] N_DONE = 6'h3F;
   localparam logic [1:0] C_ZERO = 2'h0;

   // packing modes and rotations
   localparam logic [1:0] PMODE_FOUR = 2'h0;
   localparam logic [1:0] PMODE_THREE = 2'h1;
   localparam logic [1:0] PMODE_TWO = 2'h2;
   localparam int ROT_FOUR = 6;
   localparam int ROT_THREE = 8;
   localparam int ROT_TWO = 12;
   localparam logic [WORD_W-1:0] MASK_FOUR = 24'h00003F;
   localparam logic [WORD_W-1:0] MASK_THREE = 24'h0000FF;
   localparam logic [WORD_W-1:0] MASK_TWO = 24'h000FFF;

   // channel matrix contents
   localparam logic [ADDR_W-1:0] RESP_BASE = 14'h0040;
   localparam logic [NUM_CH-1:0] DIR_OUT_MASK = 48'hAAAAAAAAAAAA;
   localparam logic [NUM_CH-1:0] FAST_MASK = 48'h00000000FFFF;
   localparam logic [SPD_W-1:0] SPD_HI_A = 3'h4;
   localparam logic [SPD_W-1:0] SPD_HI_B = 3'h7;
   localparam logic [SPD_W-1:0] SPD_LO_A = 3'h1;
   localparam logic [SPD_W-1:0] SPD_LO_B = 3'h2;

   // sequence timing
   localparam int CLK_MHZ = 200;
   localparam real FAST_TIME_US = 12.7;
   localparam real SLOW_TIME_US = 30.7;
   localparam int FAST_CYC = int'(FAST_TIME_US * CLK_MHZ);
   localparam int SLOW_CYC = int'(SLOW_TIME_US * CLK_MHZ);
   localparam int TMR_W = 16;

   // register map
   localparam logic [RADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [RADDR_W-1:0] REG_STAT = 8'h04;
   localparam logic [RADDR_W-1:0] REG_IRQ_STAT = 8'h08;
   localparam logic [RADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [RADDR_W-1:0] REG_LAST_CW = 8'h10;
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_XFER_BIT = 1;
   localparam logic CTRL_RST = 1'b0;
   localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

   typedef enum logic [7:0] {
      S_IDLE   = 8'h01,
      S_CW_RD  = 8'h02,
      S_CW_UPD = 8'h04,
      S_CW_WR  = 8'h08,
      S_DAT_RD = 8'h10,
      S_DAT_XF = 8'h20,
      S_DAT_WR = 8'h40,
      S_PAD    = 8'h80
   } tio_state_type;
endpackage : tio_pkg

// *** sim/table_io_memory_sequencer_tb.sv ***
/* testbench: channel interrupts and register port against the
   memory/device model; one table per packing mode.
   assumes the bound checker and the partner model. */
`timescale 1ns/10ps
module table_io_memory_sequencer_tb;
   localparam int SLOW = 40;
   logic clk, rst, reg_wr, reg_rd, irq, mem_rd, mem_wr, done_seen;
   logic dev_in_ack, dev_out_strobe, cpu_hold, table_done;
   logic [47:0] chan_irq;
   logic [13:0] mem_addr, y;
   logic [23:0] mem_wdata, mem_rdata, dev_out_data, dev_in_data;
   logic [23:0] w, c, mask;
   logic [5:0] dev_code, table_done_chan;
   logic [7:0] reg_addr;
   logic [1:0] p;
   logic [31:0] reg_wdata, reg_rdata, rv;
   int num_errors, samples_checked, cycles, hold_len, ch, n, wd, exp_len;
   int chs[4] = '{16, 17, 18, 1};
   logic [1:0] pmode[4] = '{2'h2, 2'h1, 2'h0, 2'h3};
   logic [23:0] w0[4] = '{24'hFFFFFF, 24'hA1B2C3, 24'hFFFFFF, 24'h5A5A5A};

   tio_sequencer #(.SLOW_CYCLES(SLOW)) dut (.clk, .rst, .chan_irq, .mem_rd,
      .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .dev_code, .dev_in_ack,
      .dev_out_strobe, .dev_out_data, .dev_in_data, .cpu_hold, .table_done,
      .table_done_chan, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq);
   tio_periph_model pm (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
      .mem_rdata, .dev_in_ack, .dev_out_strobe, .dev_out_data,
      .dev_in_data);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task test_done;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   task check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // fast services alone take 2540 cycles; ceiling leaves slack
   always @(posedge clk) begin
      cycles++;
      if (table_done === 1'b1) begin
         done_seen <= 1'b1;
      end
      if (cycles == 20000) begin
         num_errors++;
         test_done();
      end
   end

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // level held until the service starts, so the edge is not missed
   task svc(input int chan);
      int k;
      k = 0;
      @(posedge clk);
      chan_irq[chan] <= 1'b1;
      while (cpu_hold !== 1'b1 && k < 20) begin
         @(posedge clk);
         #1;
         k++;
      end
      chan_irq[chan] <= 1'b0;
      hold_len = 1;
      while (cpu_hold === 1'b1 && hold_len < 3000) begin
         @(posedge clk);
         #1;
         if (cpu_hold === 1'b1) begin
            hold_len++;
         end
      end
      repeat (3) @(posedge clk);
   endtask : svc

   function automatic logic [23:0] rotl(input logic [23:0] x, input int s);
      return (x << s) | (x >> (24 - s));
   endfunction : rotl

   initial begin
      rst = 1'b1;
      chan_irq = '0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      done_seen = 1'b0;
      num_errors = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(tio_pkg::REG_CTRL, rv);
      check(rv, 32'h0, "ctrl reset");
      rd(tio_pkg::REG_IRQ_MASK, rv);
      check(rv, 32'h0, "mask reset");
      rd(8'h20, rv);
      check(rv, 32'h0, "unmapped");
      wr(tio_pkg::REG_CTRL, 32'h1);
      wr(tio_pkg::REG_IRQ_MASK, 32'h3);
      for (int i = 0; i < 4; i++) begin
         ch = chs[i];
         p = pmode[i];
         n = 4 - int'(p);
         wd = 24 / n;
         mask = 24'hFFFFFF >> (24 - wd);
         y = 14'h00FF + 14'(i * 16);
         // one word left, count primed from the mode as software does
         pm.mem[14'h0040 + 14'(ch)] = {6'h3E, p, p, y};
         pm.mem[y + 14'h1] = w0[i];
         w = (ch % 2 == 1) ? w0[i] : 24'h0;
         if (i == 3) begin
            wr(tio_pkg::REG_IRQ_MASK, 32'h0);
         end
         exp_len = (ch < 16) ? tio_pkg::FAST_CYC : SLOW;
         for (int k = 0; k < n; k++) begin
            c = pm.dev_in_data;
            done_seen = 1'b0;
            svc(ch);
            w = rotl(w, wd) | ((ch % 2 == 1) ? 24'h0 : (c & mask));
            if (ch % 2 == 1) begin
               check(32'(pm.out_ff), 32'(w & mask), "out char");
            end
            check(32'(hold_len), 32'(exp_len), "len");
            check(32'(done_seen), 32'(k == n - 1), "done");
         end
         check(32'(pm.mem[y + 14'h1]), 32'(w), "word");
         check(32'(pm.mem[14'h0040 + 14'(ch)]),
            32'({6'h3F, p, p, y + 14'h1}), "cw");
         check(32'(table_done_chan), 32'(ch), "done chan");
         check(32'(dev_code), 32'(ch), "dev code");
         rd(tio_pkg::REG_STAT, rv);
         check(rv, (32'(ch) << 9) | (32'(ch) << 3), "stat");
         rd(tio_pkg::REG_LAST_CW, rv);
         check(rv, 32'({6'h3F, p, p, y + 14'h1}), "last cw");
         rd(tio_pkg::REG_IRQ_STAT, rv);
         check(rv, 32'h3, "istat");
         check(32'(irq), 32'(i != 3), "irq");
         wr(tio_pkg::REG_IRQ_STAT, 32'h3);
         rd(tio_pkg::REG_IRQ_STAT, rv);
         check(rv, 32'h0, "cleared");
         check(32'(irq), 32'h0, "irq low");
         $display("test %0d done", i);
      end
      test_done();
   end
endmodule : table_io_memory_sequencer_tb

// *** sim/tio_periph_model.sv ***
/* partner: core memory with one-cycle read and the table devices.
   assumes the bench preloads and inspects mem directly. */
`timescale 1ns/10ps
module tio_periph_model (
   input wire logic clk,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [13:0] mem_addr,
   input wire logic [23:0] mem_wdata,
   output logic [23:0] mem_rdata,
   input wire logic dev_in_ack,
   input wire logic dev_out_strobe,
   input wire logic [23:0] dev_out_data,
   output logic [23:0] dev_in_data
);
   // 14-bit address: nothing above the low 16K exists
   logic [23:0] mem [0:16383];
   logic [23:0] out_ff;
   initial begin
      dev_in_data = 24'h000021;
      mem_rdata = 24'h000000;
      out_ff = 24'h000000;
   end
   always @(posedge clk) begin
      // stale read data flips each cycle so it never looks valid
      mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
      if (dev_in_ack) begin
         dev_in_data <= dev_in_data + 24'h000001;
      end
      if (dev_out_strobe) begin
         out_ff <= dev_out_data;
      end
   end
endmodule : tio_periph_model

// *** sim/tio_seq_asserts.sv ***
/* checker: port-level assertions on the table transfer sequencer.
   assumes the fixed step order of one service and one clock. */
`timescale 1ns/10ps
module tio_seq_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [13:0] mem_addr,
   input wire logic [23:0] mem_wdata,
   input wire logic [23:0] mem_rdata,
   input wire logic [5:0] dev_code,
   input wire logic dev_in_ack,
   input wire logic dev_out_strobe,
   input wire logic cpu_hold,
   input wire logic table_done
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_cw_fetch:
   assert property ($rose(cpu_hold) |-> mem_rd && mem_addr[13:6] == 8'h01)
      else $error("control word not fetched first");
   chk_cw_back:
   assert property ($rose(cpu_hold) |-> ##2 mem_wr &&
      mem_addr == $past(mem_addr, 2))
      else $error("control word not written back");
   chk_addr_step:
   assert property ($rose(cpu_hold) ##2 1 |-> mem_wdata[13:0] ==
      $past(mem_rdata[13:0]) +
      14'($past(mem_rdata[17:16]) == $past(mem_rdata[15:14])))
      else $error("address field step wrong");
   chk_word_carry:
   assert property ($rose(cpu_hold) ##2 1 |-> mem_wdata[23:18] ==
      $past(mem_rdata[23:18]) + 6'($past(mem_rdata[17:16]) == 2'h3))
      else $error("word count carry wrong");
   chk_count_reload:
   assert property ($rose(cpu_hold) ##2 1 |->
      mem_wdata[15:14] == $past(mem_rdata[15:14]) &&
      mem_wdata[17:16] == (($past(mem_rdata[17:16]) == 2'h3) ?
      mem_wdata[15:14] : $past(mem_rdata[17:16]) + 2'h1))
      else $error("character count update wrong");
   chk_data_path:
   assert property ($rose(cpu_hold) |-> ##3 mem_rd &&
      mem_addr == $past(mem_wdata[13:0]) ##2 mem_wr &&
      mem_addr == $past(mem_addr, 2))
      else $error("data word not read and rewritten");
   chk_one_char:
   assert property ($rose(cpu_hold) |-> ##5 (dev_out_strobe ^ dev_in_ack)
      && dev_out_strobe == dev_code[0])
      else $error("character move or direction wrong");
   chk_idle_quiet:
   assert property (!cpu_hold |-> !mem_wr && !dev_out_strobe && !dev_in_ack)
      else $error("activity outside a service");
   chk_done_pulse:
   assert property (table_done |=> !table_done)
      else $error("completion not a pulse");
endmodule : tio_seq_asserts

bind tio_sequencer tio_seq_asserts chk_i (.clk, .rst, .mem_rd, .mem_wr,
   .mem_addr, .mem_wdata, .mem_rdata, .dev_code, .dev_in_ack,
   .dev_out_strobe, .cpu_hold, .table_done);
